//--- rtl/phase_step_pkg.sv
// shared constants for the clock synthesiser phase-step control ends
package phase_step_pkg;
    // counter setting layout: eight count bits and one bypass flag on top
    localparam int SETTING_W = 9;
    localparam int COUNT_W = 8;
    localparam int BYPASS_BIT = 8;
    localparam int FACTOR_W = 9;
    // counter slots in the setting vector
    localparam int NUM_OUT_CNT = 7;
    localparam int NUM_CNT = 9;
    localparam int SLOT_PRE = 0;
    localparam int SLOT_FB = 1;
    localparam int SLOT_OUT0 = 2;
    // phase-tap slots: feedback first, then the output counters
    localparam int NUM_TAP = 8;
    localparam int TAP_W = 3;
    localparam int TAP_FB = 0;
    localparam int TAP_OUT0 = 1;
    // counter-select codes
    localparam int SEL_W = 4;
    localparam logic [3:0] SEL_ALL_OUT = 4'h0;
    localparam logic [3:0] SEL_FB = 4'h1;
    localparam logic [3:0] SEL_OUT0 = 4'h2;
    localparam logic [3:0] SEL_OUT_LAST = 4'h8;
    // post-scale divider: bit low means bypassed
    localparam logic POST_BYPASS_VAL = 1'b0;
    localparam logic [1:0] POST_DIV_BYPASS = 2'h1;
    localparam logic [1:0] POST_DIV_ACTIVE = 2'h2;
    localparam logic [FACTOR_W-1:0] FACTOR_ONE = 9'h001;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_COMPLETE_LOW_TIME_NS = 20;
    localparam int STEP_COMPLETE_LOW_CYCLES =
        (STEP_COMPLETE_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_REQ_MIN_CYCLES = 2;
    localparam logic [7:0] LOW_CNT_W8 = 8'h00;
endpackage : phase_step_pkg

//--- rtl/phase_step_if.sv
// phase-step handshake between core logic and the synthesiser control
`timescale 1ns/100ps
interface phase_step_if;
    logic step_req;
    logic step_up;
    logic [3:0] counter_sel;
    logic step_done;
    modport dev (
        input step_req,
        input step_up,
        input counter_sel,
        output step_done
    );
    modport host (
        output step_req,
        output step_up,
        output counter_sel,
        input step_done
    );
endinterface : phase_step_if

//--- rtl/phase_step_device.sv
// synthesiser side: counter bypass decode and dynamic phase-step engine
`timescale 1ns/100ps
module phase_step_device
    import phase_step_pkg::*;
#(
    parameter int LOW_CYCLES = STEP_COMPLETE_LOW_CYCLES
) (
    input wire logic MCLK, // free-running reconfiguration clock
    input wire logic SYS_RST, // synchronous reset, active high
    phase_step_if.dev PS, // phase-step handshake
    input wire logic [NUM_CNT*SETTING_W-1:0] CNT_SETTING, // pre, fb, out0..6 settings
    input wire logic [NUM_OUT_CNT*COUNT_W-1:0] OUT_LOW_COUNT, // out0..6 low counts
    input wire logic POST_DIV_BIT, // post-scale divider bit
    output logic [NUM_CNT*FACTOR_W-1:0] CNT_FACTOR, // effective factors
    output logic [1:0] POST_DIV, // effective post-scale divide
    output logic [NUM_TAP*TAP_W-1:0] PHASE_TAP, // fb, out0..6 phase taps
    output logic [NUM_TAP-1:0] CLK_ACTIVE, // per-clock running flag
    output logic STEP_BUSY // step in progress
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ARM = 3'b001,
        ST_SHIFT = 3'b010,
        ST_LOW = 3'b011,
        ST_RELEASE = 3'b100
    } step_state_t;

    // the low-time counter is eight bits wide
    if (LOW_CYCLES < 1 || LOW_CYCLES > 255) begin : g_bad_low_cycles
        $error("LOW_CYCLES must be 1..255");
    end

    step_state_t state_reg;
    logic req_cap_reg;
    logic dir_reg;
    logic [3:0] sel_reg;
    logic [7:0] low_cnt_reg;
    logic done_reg;
    logic [NUM_TAP*TAP_W-1:0] tap_reg;
    logic [NUM_TAP-1:0] tap_hit;

    // the request is sampled away from the edge on which the core moves it
    always_ff @(negedge MCLK) begin
        if (SYS_RST) begin
            req_cap_reg <= 1'b0;
        end else begin
            req_cap_reg <= PS.step_req;
        end
    end

    // handshake sequencer; the re-arm waits for the request to drop so a
    // long pulse still yields a single step
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (req_cap_reg) begin
                        state_reg <= ST_ARM;
                    end
                end
                ST_ARM: state_reg <= ST_SHIFT;
                ST_SHIFT: state_reg <= ST_LOW;
                ST_LOW: begin
                    if (low_cnt_reg == 8'(LOW_CYCLES - 1)) begin
                        state_reg <= ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    if (!req_cap_reg) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // direction and select are taken on the second rising edge after capture
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            dir_reg <= 1'b0;
            sel_reg <= SEL_ALL_OUT;
        end else if (state_reg == ST_ARM) begin
            dir_reg <= PS.step_up;
            sel_reg <= PS.counter_sel;
        end
    end

    // done drops on the latch edge; low time is a local count standing in
    // for the synthesiser's own settle timing
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            done_reg <= 1'b1;
            low_cnt_reg <= LOW_CNT_W8;
        end else begin
            case (state_reg)
                ST_ARM: begin
                    done_reg <= 1'b0;
                    low_cnt_reg <= LOW_CNT_W8;
                end
                ST_LOW: begin
                    low_cnt_reg <= low_cnt_reg + 8'h01;
                    if (low_cnt_reg == 8'(LOW_CYCLES - 1)) begin
                        done_reg <= 1'b1;
                    end
                end
                default: low_cnt_reg <= low_cnt_reg;
            endcase
        end
    end

    // select decode: unused codes hit nothing but still complete the handshake
    always_comb begin
        tap_hit = '0;
        if (sel_reg == SEL_ALL_OUT) begin
            tap_hit = {NUM_TAP{1'b1}};
            tap_hit[TAP_FB] = 1'b0;
        end else if (sel_reg == SEL_FB) begin
            tap_hit[TAP_FB] = 1'b1;
        end else if (sel_reg >= SEL_OUT0 && sel_reg <= SEL_OUT_LAST) begin
            tap_hit[TAP_OUT0 + 32'(sel_reg - SEL_OUT0)] = 1'b1;
        end
    end

    // taps move by one of eight positions and wrap; done straight from the
    // step handshake, no scan data involved
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            tap_reg <= '0;
        end else if (state_reg == ST_SHIFT) begin
            for (int i = 0; i < NUM_TAP; i++) begin
                if (tap_hit[i]) begin
                    tap_reg[i*TAP_W +: TAP_W] <= dir_reg ?
                        tap_reg[i*TAP_W +: TAP_W] + 3'h1 :
                        tap_reg[i*TAP_W +: TAP_W] - 3'h1;
                end
            end
        end
    end

    // counter factors; a set bypass flag masks the count bits entirely
    generate
        for (genvar c = 0; c < NUM_CNT; c++) begin : g_factor
            logic [SETTING_W-1:0] setting;
            logic [FACTOR_W-1:0] factor_next;
            assign setting = CNT_SETTING[c*SETTING_W +: SETTING_W];
            if (c < SLOT_OUT0) begin : g_pre_fb
                assign factor_next = setting[BYPASS_BIT] ? FACTOR_ONE :
                    {1'b0, setting[COUNT_W-1:0]};
            end else begin : g_out
                logic [COUNT_W-1:0] low_cnt;
                assign low_cnt = OUT_LOW_COUNT[(c-SLOT_OUT0)*COUNT_W +: COUNT_W];
                assign factor_next = setting[BYPASS_BIT] ? FACTOR_ONE :
                    {1'b0, setting[COUNT_W-1:0]} + {1'b0, low_cnt};
            end
            always_ff @(posedge MCLK) begin
                if (SYS_RST) begin
                    CNT_FACTOR[c*FACTOR_W +: FACTOR_W] <= FACTOR_ONE;
                end else begin
                    CNT_FACTOR[c*FACTOR_W +: FACTOR_W] <= factor_next;
                end
            end
        end
    endgenerate

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            POST_DIV <= POST_DIV_BYPASS;
        end else begin
            POST_DIV <= (POST_DIV_BIT == POST_BYPASS_VAL) ?
                POST_DIV_BYPASS : POST_DIV_ACTIVE;
        end
    end

    // clocks are never gated: a tap change only moves an edge, so every
    // running flag stays set through the step
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            CLK_ACTIVE <= '0;
        end else begin
            CLK_ACTIVE <= {NUM_TAP{1'b1}};
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            STEP_BUSY <= 1'b0;
        end else begin
            STEP_BUSY <= (state_reg == ST_ARM) || (state_reg == ST_SHIFT) ||
                (state_reg == ST_LOW && low_cnt_reg != 8'(LOW_CYCLES - 1));
        end
    end

    assign PS.step_done = done_reg;
    assign PHASE_TAP = tap_reg;

endmodule : phase_step_device

//--- rtl/phase_step_host.sv
// core side: issues one phase step per start pulse taken while idle on the handshake; a start while busy is ignored
`timescale 1ns/100ps
module phase_step_host
    import phase_step_pkg::*;
#(
    parameter int HOLD_CYCLES = STEP_REQ_MIN_CYCLES
) (
    input wire logic MCLK, // free-running reconfiguration clock
    input wire logic SYS_RST, // synchronous reset, active high
    phase_step_if.host PS, // phase-step handshake
    input wire logic START, // one-cycle request for a step
    input wire logic UP, // direction, 1 steps up
    input wire logic [3:0] SEL, // counter select code
    output logic BUSY, // step under way
    output logic DONE // one-cycle pulse at step completion
);

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SETUP = 3'b001,
        H_PULSE = 3'b010,
        H_WAIT_LOW = 3'b011,
        H_WAIT_HIGH = 3'b100
    } host_state_t;

    // the hold counter is eight bits wide
    if (HOLD_CYCLES < STEP_REQ_MIN_CYCLES || HOLD_CYCLES > 255) begin : g_bad_hold_cycles
        $error("HOLD_CYCLES must be 2..255");
    end

    host_state_t state_reg;
    logic [7:0] hold_reg;
    logic req_reg;
    logic low_seen_reg;
    logic up_reg;
    logic [3:0] sel_reg;

    // MCLK is the free-running clock the device also steps on
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_reg <= H_IDLE;
            hold_reg <= 8'h00;
            req_reg <= 1'b0;
            low_seen_reg <= 1'b0;
            up_reg <= 1'b0;
            sel_reg <= SEL_ALL_OUT;
            BUSY <= 1'b0;
            DONE <= 1'b0;
        end else begin
            DONE <= 1'b0;
            case (state_reg)
                H_IDLE: begin
                    if (START) begin
                        up_reg <= UP;
                        sel_reg <= SEL;
                        BUSY <= 1'b1;
                        state_reg <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    req_reg <= 1'b1;
                    low_seen_reg <= 1'b0;
                    hold_reg <= 8'h01;
                    state_reg <= H_PULSE;
                end
                H_PULSE: begin
                    // a long pulse can outlast the low time; without this the
                    // host would wait forever for a drop it has already missed
                    if (!PS.step_done) begin
                        low_seen_reg <= 1'b1;
                    end
                    if (hold_reg == 8'(HOLD_CYCLES)) begin
                        req_reg <= 1'b0;
                        state_reg <= H_WAIT_LOW;
                    end else begin
                        hold_reg <= hold_reg + 8'h01;
                    end
                end
                H_WAIT_LOW: begin
                    if (!PS.step_done || low_seen_reg) begin
                        state_reg <= H_WAIT_HIGH;
                    end
                end
                H_WAIT_HIGH: begin
                    if (PS.step_done) begin
                        BUSY <= 1'b0;
                        DONE <= 1'b1;
                        state_reg <= H_IDLE;
                    end
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end

    assign PS.step_req = req_reg;
    assign PS.step_up = up_reg;
    assign PS.counter_sel = sel_reg;

endmodule : phase_step_host

//--- verif/phase_step_chk.sv
// assertions on the phase-step handshake wires between the two ends
`timescale 1ns/100ps
module phase_step_chk (
    input wire logic MCLK, // reconfiguration clock
    input wire logic SYS_RST, // synchronous reset
    input wire logic step_req, // step request
    input wire logic step_up, // direction
    input wire logic [3:0] counter_sel, // select code
    input wire logic step_done // completion flag
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);
    ready_at_reset_a: assert property ($past(SYS_RST) |-> step_done)
        else $error("completion flag low after reset");
    done_drop_time_a: assert property (
        $rose(step_req) && step_done |-> ##1 step_done ##1 !step_done)
        else $error("completion flag did not drop on the second edge");
    // low time is internal, so only a short window is allowed rather than one figure
    low_time_a: assert property (
        $fell(step_done) |-> !step_done ##1 !step_done ##[1:2] step_done)
        else $error("completion flag low time out of range");
    drop_cause_a: assert property ($fell(step_done) |-> $past(step_req, 2))
        else $error("completion flag dropped without a request");
    req_width_a: assert property ($rose(step_req) |-> step_req [*2])
        else $error("step request shorter than two cycles");
    req_when_ready_a: assert property ($rose(step_req) |-> step_done)
        else $error("step request raised while a step runs");
    ctrl_stable_a: assert property (step_req |-> $stable(counter_sel) && $stable(step_up))
        else $error("select or direction moved under a request");
    req_released_a: assert property ($rose(step_done) |-> !step_req ##1 step_done)
        else $error("request not released before the flag returned");
endmodule : phase_step_chk

//--- verif/tb_top.sv
// self-checking bench joining the core end and the synthesiser end
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top
    import phase_step_pkg::*;
;
    logic MCLK = 0, SYS_RST = 1, start = 0, up = 0, post_bit = 0;
    logic [3:0] sel = 4'h0;
    logic [NUM_CNT*SETTING_W-1:0] setting = '0;
    logic [NUM_OUT_CNT*COUNT_W-1:0] low = '0;
    logic [NUM_CNT*FACTOR_W-1:0] factor;
    logic [1:0] post_div;
    logic [NUM_TAP*TAP_W-1:0] tap;
    logic [NUM_TAP-1:0] clk_active;
    logic step_busy, busy, done;
    logic [2:0] exp_tap [NUM_TAP];
    logic [31:0] seed = 32'h1e148bd4;
    int fails = 0, num_checks = 0;
    phase_step_if ps ();
    phase_step_device #(.LOW_CYCLES(2)) u_phase_step_device (.MCLK(MCLK), .SYS_RST(SYS_RST),
        .PS(ps), .CNT_SETTING(setting), .OUT_LOW_COUNT(low), .POST_DIV_BIT(post_bit),
        .CNT_FACTOR(factor), .POST_DIV(post_div), .PHASE_TAP(tap), .CLK_ACTIVE(clk_active),
        .STEP_BUSY(step_busy));
    phase_step_host u_phase_step_host (.MCLK(MCLK), .SYS_RST(SYS_RST), .PS(ps), .START(start),
        .UP(up), .SEL(sel), .BUSY(busy), .DONE(done));
    phase_step_chk u_phase_step_chk (.MCLK(MCLK), .SYS_RST(SYS_RST), .step_req(ps.step_req),
        .step_up(ps.step_up), .counter_sel(ps.counter_sel), .step_done(ps.step_done));
    initial begin
        forever #5 MCLK = ~MCLK;
    end
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [FACTOR_W-1:0] exp_factor(input int s);
        logic [SETTING_W-1:0] c;
        c = setting[s*SETTING_W +: SETTING_W];
        if (c[BYPASS_BIT]) return FACTOR_ONE;
        if (s < SLOT_OUT0) return {1'b0, c[COUNT_W-1:0]};
        return {1'b0, c[COUNT_W-1:0]} + {1'b0, low[(s-SLOT_OUT0)*COUNT_W +: COUNT_W]};
    endfunction : exp_factor
    task complete_run();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    task automatic reset_dut(input int cycles);
        SYS_RST = 1'b1;
        repeat (cycles) @(negedge MCLK);
        SYS_RST = 1'b0;
        for (int k = 0; k < NUM_TAP; k++) exp_tap[k] = 3'h0;
        @(negedge MCLK);
        `CHK(ps.step_done, 1'b1)
        `CHK(tap, 24'h0)
        `CHK(clk_active, 8'hff)
    endtask : reset_dut
    // mode 1 forces every bypass flag over random count bits, mode 2 the largest sums
    task automatic check_factors(input int mode);
        logic [95:0] w;
        w = {rnd(), rnd(), rnd()};
        setting = w[80:0];
        w = {rnd(), rnd(), rnd()};
        low = w[55:0];
        post_bit = w[60];
        for (int s = 0; s < NUM_CNT; s++) begin
            if (mode == 1) setting[s*SETTING_W+BYPASS_BIT] = 1'b1;
            if (mode == 2) setting[s*SETTING_W +: SETTING_W] = 9'h0ff;
        end
        if (mode == 2) low = '1;
        @(negedge MCLK);
        for (int s = 0; s < NUM_CNT; s++) begin
            `CHK(factor[s*FACTOR_W +: FACTOR_W], exp_factor(s))
        end
        `CHK(post_div, post_bit ? POST_DIV_ACTIVE : POST_DIV_BYPASS)
    endtask : check_factors
    // poke raises a second start while busy: it must be dropped, not queued
    task automatic step(input logic [3:0] s, input logic u, input logic poke);
        int n;
        logic [2:0] d;
        start = 1'b1;
        up = u;
        sel = s;
        @(negedge MCLK);
        start = 1'b0;
        if (poke) begin
            repeat (2) @(negedge MCLK);
            start = 1'b1;
            sel = ~s;
            up = ~u;
            @(negedge MCLK);
            start = 1'b0;
        end
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge MCLK);
            n++;
            `CHK(clk_active, 8'hff)
            `CHK(busy, ~done)
            `CHK(step_busy, ~ps.step_done)
        end
        `CHK(done, 1'b1)
        d = u ? 3'h1 : 3'h7;
        for (int k = 0; k < NUM_TAP; k++) begin
            if ((s == SEL_ALL_OUT && k >= TAP_OUT0) || (s == SEL_FB && k == TAP_FB)
                || (s >= SEL_OUT0 && s <= SEL_OUT_LAST && k == s - 1)) exp_tap[k] += d;
        end
        for (int k = 0; k < NUM_TAP; k++) begin
            `CHK(tap[k*TAP_W +: TAP_W], exp_tap[k])
        end
    endtask : step
    initial begin
        logic [31:0] r;
        reset_dut(16);
        check_factors(1);
        check_factors(2);
        repeat (6) check_factors(0);
        for (int i = 0; i < 16; i++) step(4'(i), 1'b1, i == 5);
        repeat (24) begin
            r = rnd();
            step(r[3:0], r[4], 1'b0);
        end
        reset_dut(2);
        step(SEL_FB, 1'b0, 1'b0);
        step(SEL_ALL_OUT, 1'b0, 1'b1);
        complete_run();
    end
    initial begin
        #100000;
        fails++;
        complete_run();
    end
endmodule : tb_top
